// ### bbs_exec.sv
// Decode and execute for the conditional and unconditional relative branches
// and the single-bit set of a data-memory register.
// Assumes fetch presents a new opcode each Q1 with its address; data memory
// answers a read address combinationally with rd_data.
//
// Summary of operation
// - Opcode E3xx branches only when the carry flag is zero.
// - Opcode E7xx branches only when the negative flag is zero and changes no flag.
// - Opcode E5xx branches only when the overflow flag is zero.
// - Opcode E1xx branches only when the zero flag is zero.
// - The conditional target is branch address plus 2 plus twice the signed 8-bit offset.
// - A conditional branch takes one cycle if not taken and two if taken, the second a no-op.
// - Opcode prefix 11010 always jumps to address plus 2 plus twice the signed 11-bit offset.
// - The unconditional jump always takes two cycles, the second a no-op, and changes no flag.
// - Opcode 1000 bbba ffff ffff sets bit b of file register f and leaves all else alone.
// - Access selector zero targets the access bank, one uses the bank select register.
// - With selector zero, extended set on and f at or below 5Fh, indexed literal offset is used.
`timescale 1ns/1ps
module bbs_exec
  import bbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fetch path
  input wire logic [15:0] opcode,
  input wire logic [20:0] opcode_addr,
  // Status flags
  input wire logic flag_carry,
  input wire logic flag_neg,
  input wire logic flag_ovf,
  input wire logic flag_zero,
  // Addressing context
  input wire logic [3:0] bank_select_reg,
  input wire logic [11:0] index_base,
  input wire logic ext_set_en,
  // Data memory
  input wire logic [7:0] rd_data,
  output logic [11:0] mem_addr,
  output logic [7:0] wr_data,
  output logic wr_en,
  // Program counter and pipeline control
  output logic [20:0] pc_load_val,
  output logic pc_load,
  output logic flush,
  output bbs_phase_t phase,
  output logic flags_wr_en,
  output logic unknown_op
);

  // Sign-extend a halved offset and form the target
  function automatic logic [20:0] rel_target(input logic [20:0] base, input logic [10:0] off);
    logic [20:0] ext;
    ext = {{10{off[10]}}, off};
    rel_target = base + BBS_PC_STEP + {ext[19:0], 1'b0};
  endfunction

  bbs_phase_gen u_phase
  (
    .clk(clk),
    .srst(srst),
    .phase(phase)
  );

  // Latched opcode and state
  logic [15:0] op_r;
  logic [15:0] op_nxt;
  logic [20:0] addr_r;
  logic [20:0] addr_nxt;
  logic nop_r;
  logic nop_nxt;
  logic take_r;
  logic take_nxt;
  logic [11:0] ea_r;
  logic [11:0] ea_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic wr_en_r;
  logic wr_en_nxt;
  logic [20:0] pc_val_r;
  logic [20:0] pc_val_nxt;
  logic pc_load_r;
  logic pc_load_nxt;
  logic flush_r;
  logic flush_nxt;
  logic unk_r;
  logic unk_nxt;

  // Decoded classes of the latched opcode
  logic is_cond;
  logic is_jump;
  logic is_bset;
  logic cond_met;
  logic [2:0] bit_sel;
  logic [7:0] file_addr;

  // Decode of the held opcode
  always_comb
  begin
    is_jump = op_r[15:11] == BBS_OP_JUMP_ALWAYS;
    is_bset = op_r[15:12] == BBS_OP_BIT_SET;
    bit_sel = op_r[BBS_BIT_POS_LSB +: 3];
    file_addr = op_r[7:0];
    is_cond = 1'b1;
    cond_met = 1'b0;
    unique case (op_r[15:8])
      BBS_OP_BR_CARRY_CLR: cond_met = !flag_carry;
      BBS_OP_BR_NEG_CLR: cond_met = !flag_neg;
      BBS_OP_BR_OVF_CLR: cond_met = !flag_ovf;
      BBS_OP_BR_ZERO_CLR: cond_met = !flag_zero;
      default: is_cond = 1'b0;
    endcase
  end

  // Phase-ordered execution of the held instruction
  always_comb
  begin
    op_nxt = op_r;
    addr_nxt = addr_r;
    nop_nxt = nop_r;
    take_nxt = take_r;
    ea_nxt = ea_r;
    data_nxt = data_r;
    wr_en_nxt = 1'b0;
    pc_val_nxt = pc_val_r;
    pc_load_nxt = 1'b0;
    flush_nxt = 1'b0;
    unk_nxt = unk_r;
    unique case (phase)
      BBS_Q1:
      begin
        // Decode: latch opcode; a discarded slot becomes a no-op
        op_nxt = opcode;
        addr_nxt = opcode_addr;
        // drop the slot after a taken branch
        nop_nxt = take_r;
        take_nxt = 1'b0;
      end
      BBS_Q2:
      begin
        unk_nxt = !nop_r && !is_cond && !is_jump && !is_bset;
        if (!nop_r && is_bset)
        begin
          // indexed literal offset for low access addresses
          if (!op_r[BBS_ACC_SEL_POS] && ext_set_en && file_addr <= BBS_INDEXED_LIMIT)
            ea_nxt = index_base + {4'h0, file_addr};
          // access bank low or high half
          else if (!op_r[BBS_ACC_SEL_POS])
            ea_nxt = (file_addr <= BBS_INDEXED_LIMIT) ? {4'h0, file_addr} : {4'hF, file_addr};
          else
            ea_nxt = {bank_select_reg, file_addr};
        end
      end
      BBS_Q3:
      begin
        if (!nop_r && is_bset)
          data_nxt = rd_data | (8'h01 << bit_sel);
        if (!nop_r && is_cond && cond_met)
        begin
          take_nxt = 1'b1;
          pc_val_nxt = rel_target(addr_r, {{3{op_r[7]}}, op_r[7:0]});
        end
        else if (!nop_r && is_jump)
        begin
          take_nxt = 1'b1;
          pc_val_nxt = rel_target(addr_r, op_r[10:0]);
        end
      end
      BBS_Q4:
      begin
        // write back with one bit set
        if (!nop_r && is_bset)
          wr_en_nxt = 1'b1;
        // load PC and flush for a second no-op cycle
        if (take_r)
        begin
          pc_load_nxt = 1'b1;
          flush_nxt = 1'b1;
        end
      end
    endcase
  end

  // Registers of the execute state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      op_r <= 16'h0000;
      addr_r <= BBS_PC_RST;
      nop_r <= 1'b1;
      take_r <= 1'b0;
      ea_r <= 12'h000;
      data_r <= 8'h00;
      wr_en_r <= 1'b0;
      pc_val_r <= BBS_PC_RST;
      pc_load_r <= 1'b0;
      flush_r <= 1'b0;
      unk_r <= 1'b0;
    end
    else
    begin
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      nop_r <= nop_nxt;
      take_r <= take_nxt;
      ea_r <= ea_nxt;
      data_r <= data_nxt;
      wr_en_r <= wr_en_nxt;
      pc_val_r <= pc_val_nxt;
      pc_load_r <= pc_load_nxt;
      flush_r <= flush_nxt;
      unk_r <= unk_nxt;
    end
  end

  // Outputs; none of these instructions write flags
  assign mem_addr = ea_r;
  assign wr_data = data_r;
  assign wr_en = wr_en_r;
  assign pc_load_val = pc_val_r;
  assign pc_load = pc_load_r;
  assign flush = flush_r;
  assign flags_wr_en = 1'b0;
  assign unknown_op = unk_r;

endmodule

// ### bbs_exec_asserts.sv
// Checker for bbs_exec branch redirects, bit-set write-back and discards.
// Assumes a bind to bbs_exec with one clock and synchronous reset.
`timescale 1ns/1ps
module bbs_exec_asserts
  import bbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs
  input wire logic [15:0] opcode,
  input wire logic [20:0] opcode_addr,
  input wire logic flag_carry,
  input wire logic flag_neg,
  input wire logic flag_ovf,
  input wire logic flag_zero,
  input wire logic [3:0] bank_select_reg,
  input wire logic [7:0] rd_data,
  // Outputs
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic [20:0] pc_load_val,
  input wire logic pc_load,
  input wire logic flush,
  input wire bbs_phase_t phase
);
  logic [3:0] fl;
  logic [20:0] ctgt;
  logic [20:0] jtgt;
  // Flag per selector and both targets
  assign fl = {flag_neg, flag_ovf, flag_carry, flag_zero};
  assign ctgt = opcode_addr + BBS_PC_STEP + {{12{opcode[7]}}, opcode[7:0], 1'b0};
  assign jtgt = opcode_addr + BBS_PC_STEP + {{9{opcode[10]}}, opcode[10:0], 1'b0};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Slot starts not discarded
  sequence s_cond;
    phase == BBS_Q1 && !pc_load && opcode[15:12] == 4'hE && !opcode[11] && opcode[8];
  endsequence
  sequence s_set;
    phase == BBS_Q1 && !pc_load && opcode[15:12] == BBS_OP_BIT_SET;
  endsequence
  property p_taken;
    s_cond ##2 !fl[$past(opcode[10:9], 2)] |-> ##2 pc_load && pc_load_val == $past(ctgt, 4);
  endproperty
  a_taken: assert property (p_taken) else $error("branch target wrong");
  property p_not_taken;
    s_cond ##2 fl[$past(opcode[10:9], 2)] |-> ##2 !pc_load;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("branch taken on set flag");
  property p_jump;
    phase == BBS_Q1 && !pc_load && opcode[15:11] == BBS_OP_JUMP_ALWAYS |-> ##4 pc_load && pc_load_val == $past(jtgt, 4);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_pulse;
    pc_load |-> flush ##1 !pc_load;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse wrong");
  property p_set;
    s_set |-> ##3 wr_data == ($past(rd_data) | 8'(8'h01 << $past(opcode[11:9], 3))) ##1 wr_en;
  endproperty
  a_set: assert property (p_set) else $error("bit set data wrong");
  property p_wr_once;
    wr_en |=> !wr_en [*3];
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("extra write");
  property p_bank;
    s_set ##0 opcode[8] |-> ##2 mem_addr == {$past(bank_select_reg), $past(opcode[7:0], 2)};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_discard;
    phase == BBS_Q1 && pc_load |-> ##4 !wr_en && !pc_load;
  endproperty
  a_discard: assert property (p_discard) else $error("discarded op acted");
endmodule

bind bbs_exec bbs_exec_asserts bbs_exec_asserts_i (.clk, .srst, .opcode, .opcode_addr, .flag_carry, .flag_neg,
  .flag_ovf, .flag_zero, .bank_select_reg, .rd_data, .mem_addr, .wr_data, .wr_en, .pc_load_val, .pc_load, .flush,
  .phase);

// ### bbs_exec_tb.sv
// Self-checking bench for bbs_exec with a data memory partner.
// Assumes 200 MHz clk; stimulus changes on the falling edge.
`timescale 1ns/1ps
module bbs_exec_tb;
  import bbs_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ext_set_en = 1'b0, flag_carry = 1'b0, flag_neg = 1'b0, flag_ovf = 1'b0;
  logic flag_zero = 1'b0, taken_r = 1'b0;
  logic [15:0] opcode = 16'h0;
  logic [20:0] opcode_addr = 21'h0;
  logic [3:0] bank_select_reg = 4'h0;
  logic [11:0] index_base = 12'h0;
  logic [7:0] rd_data, wr_data;
  logic [11:0] mem_addr;
  logic [20:0] pc_load_val;
  logic wr_en, pc_load, flush, flags_wr_en, unknown_op;
  bbs_phase_t phase;
  int fails = 0, n_compared = 0;
  // Clock
  always #2.5 clk = ~clk;
  bbs_exec bbs_exec_i (.clk, .srst, .opcode, .opcode_addr, .flag_carry, .flag_neg, .flag_ovf, .flag_zero,
    .bank_select_reg, .index_base, .ext_set_en, .rd_data, .mem_addr, .wr_data, .wr_en, .pc_load_val, .pc_load,
    .flush, .phase, .flags_wr_en, .unknown_op);
  bbs_mem_model bbs_mem_model_i (.clk, .mem_addr, .wr_data, .wr_en, .rd_data);
  // Compare and count
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Expected effective file address
  function automatic logic [11:0] ea(input logic [8:0] af, input logic [3:0] b, input logic [11:0] ib, input logic x);
    if (af[8])
      return {b, af[7:0]};
    if (x && af[7:0] <= BBS_INDEXED_LIMIT)
      return ib + 12'(af[7:0]);
    return {(af[7:0] > BBS_INDEXED_LIMIT) ? 4'hF : 4'h0, af[7:0]};
  endfunction
  // Random opcode of a chosen kind
  function automatic logic [15:0] pick;
    logic [15:0] r = 16'($urandom);
    case (r[15:14])
      2'h0: return {4'hE, 1'b0, r[13:12], 1'b1, r[7:0]};
      2'h1: return {BBS_OP_JUMP_ALWAYS, r[10:0]};
      2'h2: return {BBS_OP_BIT_SET, r[11:0]};
      default: return r;
    endcase
  endfunction
  // One instruction slot, entered at a falling edge in Q1
  task automatic slot(input logic [15:0] op, input logic [3:0] fl);
    logic tk;
    logic st;
    logic jmp;
    logic [20:0] tgt;
    logic [11:0] a;
    logic [7:0] wd;
    logic uk;
    opcode = op;
    opcode_addr = 21'({$urandom, 1'b0});
    {flag_neg, flag_ovf, flag_carry, flag_zero} = fl;
    bank_select_reg = 4'($urandom);
    index_base = 12'($urandom);
    ext_set_en = 1'($urandom);
    jmp = op[15:11] == BBS_OP_JUMP_ALWAYS;
    tk = !taken_r && (jmp || (op[15:12] == 4'hE && !op[11] && op[8] && !fl[op[10:9]]));
    st = !taken_r && op[15:12] == BBS_OP_BIT_SET;
    // Unknown when live and none of the six handled kinds
    uk = !taken_r && !jmp && op[15:12] != BBS_OP_BIT_SET && !(op[15:12] == 4'hE && !op[11] && op[8]);
    tgt = opcode_addr + BBS_PC_STEP + (jmp ? {{9{op[10]}}, op[10:0], 1'b0} : {{12{op[7]}}, op[7:0], 1'b0});
    a = ea(op[8:0], bank_select_reg, index_base, ext_set_en);
    repeat (2) @(negedge clk);
    wd = bbs_mem_model_i.mem[a] | 8'(8'h01 << op[11:9]);
    repeat (2) @(negedge clk);
    chk(21'(pc_load), 21'(tk));
    chk(21'(flags_wr_en), 21'h0);
    chk(21'(flush), 21'(tk));
    chk(21'(unknown_op), 21'(uk));
    chk(21'(phase), 21'(BBS_Q1));
    chk(21'(wr_en), 21'(st));
    if (tk)
      chk(pc_load_val, tgt);
    if (st)
    begin
      chk(21'(mem_addr), 21'(a));
      chk(21'(wr_data), 21'(wd));
    end
    taken_r = tk;
  endtask
  // Main sequence
  initial
  begin
    static logic [15:0] cn [15] = '{16'hE380, 16'h0, 16'hE77F, 16'h0, 16'hE500, 16'h0, 16'hE1FF, 16'h0, 16'hD400,
      16'h0, 16'hD3FF, 16'h0, 16'h8FFF, 16'h8E5F, 16'h8E60};
    void'($urandom(63030));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    foreach (cn[i]) slot(cn[i], 4'h0);
    for (int i = 0; i < 300; i++)
      slot(pick(), 4'($urandom));
    print_verdict;
  end
  // Watchdog
  initial
  begin
    #20000;
    fails++;
    print_verdict;
  end
endmodule

// ### bbs_mem_model.sv
// Data memory partner for the branch and bit-set block.
// Assumes one clock; reads answer at once, writes land on wr_en.
`timescale 1ns/1ps
module bbs_mem_model(
  // Clock
  input wire logic clk,
  // Access from the block
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  output logic [7:0] rd_data
);
  logic [7:0] mem [4096];
  // Seeded contents, then the write port
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'hA5;
  always @(posedge clk) if (wr_en) mem[mem_addr] <= wr_data;
  // Combinational read
  assign rd_data = mem[mem_addr];
endmodule

// ### bbs_phase_gen.sv
// Phase sequencer: divides the core clock into four phases.
// Assumes clk is the core clock and srst a synchronous reset.
`timescale 1ns/1ps
module bbs_phase_gen
  import bbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Current phase
  output bbs_phase_t phase
);

  bbs_phase_t phase_r;
  bbs_phase_t phase_nxt;

  // Step through Q1..Q4 and wrap
  always_comb
  begin
    unique case (phase_r)
      BBS_Q1: phase_nxt = BBS_Q2;
      BBS_Q2: phase_nxt = BBS_Q3;
      BBS_Q3: phase_nxt = BBS_Q4;
      BBS_Q4: phase_nxt = BBS_Q1;
    endcase
  end

  // Phase register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_r <= BBS_Q1;
    end
    else
    begin
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;

endmodule

// ### bbs_pkg.sv
// Package for the branch and bit-set execute block: opcode patterns,
// field positions, phase encoding and reset values.
// Assumes a single 200 MHz core clock with synchronous reset.
package bbs_pkg;

  // Upper-byte patterns of the flag-conditional branches
  localparam logic [7:0] BBS_OP_BR_CARRY_CLR = 8'hE3;
  localparam logic [7:0] BBS_OP_BR_NEG_CLR = 8'hE7;
  localparam logic [7:0] BBS_OP_BR_OVF_CLR = 8'hE5;
  localparam logic [7:0] BBS_OP_BR_ZERO_CLR = 8'hE1;
  // Top five bits of the unconditional relative jump
  localparam logic [4:0] BBS_OP_JUMP_ALWAYS = 5'h1A;
  // Top nibble of the single-bit set
  localparam logic [3:0] BBS_OP_BIT_SET = 4'h8;

  // Field positions inside the 16-bit opcode
  localparam int BBS_BIT_POS_LSB = 9;
  localparam int BBS_ACC_SEL_POS = 8;
  // Highest file address that uses indexed literal offset mode
  localparam logic [7:0] BBS_INDEXED_LIMIT = 8'h5F;

  // Program counter width and its reset value
  localparam int BBS_PC_W = 21;
  localparam logic [20:0] BBS_PC_RST = 21'h000000;
  // Step from a branch to its fall-through address
  localparam logic [20:0] BBS_PC_STEP = 21'h000002;

  // Four phases of an instruction cycle
  typedef enum logic [1:0] {
    BBS_Q1,
    BBS_Q2,
    BBS_Q3,
    BBS_Q4
  } bbs_phase_t;

endpackage
